// >>> rtl/sarrd_pkg.sv
package sarrd_pkg;
  localparam int          SARRD_BITS       = 12;
  localparam int          SARRD_CNT_W      = 5;
  // Frame positions counted in falling shift clock edges after select
  localparam logic [4:0]  SARRD_EN_EDGE    = 5'h02;
  localparam logic [4:0]  SARRD_MSB_EDGE   = 5'h03;
  localparam logic [4:0]  SARRD_LSB_EDGE   = 5'h0e;
  localparam logic [4:0]  SARRD_END_EDGE   = 5'h19;
  localparam logic [4:0]  SARRD_OFF_EDGE   = 5'h1a;
  localparam logic [11:0] SARRD_RESULT_RST = 12'h000;
  localparam logic [11:0] SARRD_CODE_STEPS = 12'hfff;
  // Link clock limits, in Hz
  localparam int          SARRD_CLK_HZ     = 50000000;
  localparam int          SARRD_LINK_MIN_HZ = 10000;
  localparam int          SARRD_LINK_MAX_HZ = 3200000;
  // Shortest link half period in system cycles (rounds down, at least one)
  localparam int          SARRD_HALF_CYC   = (SARRD_CLK_HZ / (2 * SARRD_LINK_MAX_HZ)) < 1 ? 1 :
                                             (SARRD_CLK_HZ / (2 * SARRD_LINK_MAX_HZ));
  typedef enum logic [2:0] {
    SARRD_OFF,
    SARRD_SAMPLE,
    SARRD_NULL,
    SARRD_MSB_FIRST,
    SARRD_LSB_FIRST,
    SARRD_DONE
  } sarrd_state_e;
endpackage : sarrd_pkg

// >>> rtl/sarrd_dec_if.sv
`timescale 1ns/1ns
interface sarrd_dec_if;
  logic       take;
  logic [3:0] bit_idx;
  logic       decision;
  logic       hold;
  modport ctrl (output take, output bit_idx, output hold, input decision);
  modport sar  (input take, input bit_idx, input hold, output decision);
endinterface : sarrd_dec_if

// >>> rtl/sarrd_sar.sv
`timescale 1ns/1ns
module sarrd_sar
  import sarrd_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [11:0]       sample_code,
  sarrd_dec_if.sar               dec
);
  logic [11:0] held_q;
  logic [11:0] held_d;
  logic        decision_q;
  logic        decision_d;

  always_comb begin
    held_d     = held_q;
    decision_d = decision_q;
    // Input caught once per frame
    if (dec.hold) begin
      held_d = sample_code;
    end
    if (dec.take) begin
      decision_d = held_q[dec.bit_idx];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      held_q     <= SARRD_RESULT_RST;
      decision_q <= 1'b0;
    end else begin
      held_q     <= held_d;
      decision_q <= decision_d;
    end
  end

  assign dec.decision = decision_q;
endmodule : sarrd_sar

// >>> rtl/sarrd_top.sv
`timescale 1ns/1ns
// Notes on behaviour
// R1 - Select low runs, high shuts down
// R2 - Result is a twelve bit word
// R3 - Output enabled on second falling clock
// R4 - One null bit before result bits
// R5 - Bits launched on falling shift clock
// R6 - Result leaves most significant bit first
// R7 - Bits output as each decision made
// R8 - Extra clocks repeat word lsb first
// R9 - Host clock between 10 kHz and 3.2 MHz
// R10 - Input captured and held during conversion
// R11 - Sampling phase of 1.5 clocks first
// R12 - Inverting input sampled once only
// R13 - Unsigned code, step is reference/4096
// R14 - Three wire link: select, clock, data
// R15 - Host captures bits on rising edge
// R16 - After msb repeat, output released, idle
// R17 - New frame needs select high then low
// R18 - Raising select aborts conversion and output
// R19 - Power down when done or deselected (when done, only analog power drops; digital stays up until deselect)
// R20 - Deselect floats output, clears counter
module sarrd_top
  import sarrd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        select_shutdown_n,
  input  wire logic        shift_conversion_clock,
  input  wire logic [11:0] sample_code,
  output logic             serial_data_o,
  output logic             serial_data_oe,
  output logic             analog_power_up,
  output logic             digital_power_up,
  output logic             input_hold
);
  sarrd_dec_if dec ();

  logic         sel_meta_q;
  logic         sel_meta_d;
  logic         sel_sync_q;
  logic         sel_sync_d;
  logic         clk_meta_q;
  logic         clk_meta_d;
  logic         clk_sync_q;
  logic         clk_sync_d;
  logic         clk_prev_q;
  logic         clk_prev_d;
  logic         sel_prev_q;
  logic         sel_prev_d;
  logic [11:0]  code_meta_q;
  logic [11:0]  code_meta_d;
  logic [11:0]  code_sync_q;
  logic [11:0]  code_sync_d;
  sarrd_state_e state_q;
  sarrd_state_e state_d;
  logic [4:0]   edge_cnt_q;
  logic [4:0]   edge_cnt_d;
  logic [11:0]  word_q;
  logic [11:0]  word_d;
  logic [3:0]   idx_q;
  logic [3:0]   idx_d;
  logic         launch_q;
  logic         launch_d;
  logic         out_q;
  logic         out_d;
  logic         oe_q;
  logic         oe_d;
  logic         apwr_q;
  logic         apwr_d;
  logic         dpwr_q;
  logic         dpwr_d;
  logic         hold_q;
  logic         hold_d;
  logic         take_d;
  logic         fall_edge;
  logic         rise_edge;
  logic         selected;
  logic         frame_start;
  logic         power_on_ev;
  logic         analog_off_ev;
  logic         hold_ev;
  logic [11:0]  word_load;

  // Both host pins and the input word come from outside this clock
  // Input word is read long after it settles, so a plain two-flop pass is enough
  always_comb begin
    sel_meta_d  = select_shutdown_n;
    sel_sync_d  = sel_meta_q;
    clk_meta_d  = shift_conversion_clock;
    clk_sync_d  = clk_meta_q;
    clk_prev_d  = clk_sync_q;
    sel_prev_d  = sel_sync_q;
    code_meta_d = sample_code;
    code_sync_d = code_meta_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sel_meta_q  <= 1'b1;
      sel_sync_q  <= 1'b1;
      clk_meta_q  <= 1'b0;
      clk_sync_q  <= 1'b0;
      clk_prev_q  <= 1'b0;
      sel_prev_q  <= 1'b1;
      code_meta_q <= SARRD_RESULT_RST;
      code_sync_q <= SARRD_RESULT_RST;
    end else begin
      sel_meta_q  <= sel_meta_d;
      sel_sync_q  <= sel_sync_d;
      clk_meta_q  <= clk_meta_d;
      clk_sync_q  <= clk_sync_d;
      clk_prev_q  <= clk_prev_d;
      sel_prev_q  <= sel_prev_d;
      code_meta_q <= code_meta_d;
      code_sync_q <= code_sync_d;
    end
  end

  // R1 select level decode
  assign selected    = !sel_sync_q;
  // R17 frame needs high then low
  assign frame_start = sel_prev_q && !sel_sync_q;
  // R5 falling edge launches bits
  assign fall_edge   = clk_prev_q && !clk_sync_q;
  assign rise_edge   = !clk_prev_q && clk_sync_q;

  always_comb begin
    state_d    = state_q;
    edge_cnt_d = edge_cnt_q;
    word_d     = word_q;
    idx_d      = idx_q;
    launch_d   = 1'b0;
    out_d      = out_q;
    oe_d       = oe_q;
    take_d     = 1'b0;
    power_on_ev   = 1'b0;
    analog_off_ev = 1'b0;
    hold_ev       = 1'b0;
    // R7 result bit goes out as soon as decided
    // R6 msb first order from the index walk
    if (launch_q) begin
      word_d = (word_q & ~word_load) | ({SARRD_BITS{dec.decision}} & word_load);
      out_d  = dec.decision;
    end
    if (!selected) begin
      // R18 abort on deselect
      // R20 float output, clear count
      state_d    = SARRD_OFF;
      edge_cnt_d = '0;
      oe_d       = 1'b0;
      out_d      = 1'b0;
    end else begin
      case (state_q)
        SARRD_OFF: begin
          if (frame_start) begin
            // R10 track input from the select edge
            // R11 sampling until the second falling edge
            state_d     = SARRD_SAMPLE;
            power_on_ev = 1'b1;
            word_d      = SARRD_RESULT_RST;
          end
        end
        SARRD_SAMPLE: begin
          if (fall_edge) begin
            edge_cnt_d = edge_cnt_q + 5'h01;
            if (edge_cnt_q + 5'h01 == SARRD_EN_EDGE) begin
              // R3 enable on second falling edge
              // R4 null bit first
              // R12 single capture, held to the end
              hold_ev = 1'b1;
              oe_d    = 1'b1;
              out_d   = 1'b0;
              state_d = SARRD_NULL;
            end
          end
        end
        SARRD_NULL: begin
          // Decision is prepared during the null bit
          if (rise_edge) begin
            take_d = 1'b1;
            idx_d  = 4'(SARRD_BITS - 1);
          end
          if (fall_edge) begin
            edge_cnt_d = edge_cnt_q + 5'h01;
            launch_d   = 1'b1;
            state_d    = SARRD_MSB_FIRST;
          end
        end
        SARRD_MSB_FIRST: begin
          if (fall_edge) begin
            edge_cnt_d = edge_cnt_q + 5'h01;
            if (edge_cnt_q == SARRD_LSB_EDGE) begin
              // R8 repeat, lsb first
              // R19 analog side sleeps once done
              analog_off_ev = 1'b1;
              idx_d   = 4'h1;
              out_d   = word_q[1];
              state_d = SARRD_LSB_FIRST;
            end else begin
              launch_d = 1'b1;
            end
          end else if (rise_edge && idx_q != 4'h0) begin
            take_d = 1'b1;
            idx_d  = idx_q - 4'h1;
          end
        end
        SARRD_LSB_FIRST: begin
          if (fall_edge) begin
            edge_cnt_d = edge_cnt_q + 5'h01;
            if (edge_cnt_q == SARRD_END_EDGE) begin
              // R16 release after msb repeat
              oe_d    = 1'b0;
              out_d   = 1'b0;
              state_d = SARRD_DONE;
            end else begin
              idx_d = idx_q + 4'h1;
              out_d = word_q[idx_q + 4'h1];
            end
          end
        end
        SARRD_DONE: begin
          // R16 further clocks ignored
          oe_d = 1'b0;
        end
        default: begin
          state_d = SARRD_OFF;
        end
      endcase
    end
  end

  // R7 each decided bit lands in its own slot
  for (genvar b = 0; b < SARRD_BITS; b++) begin : g_word_load
    assign word_load[b] = launch_q && (idx_q == 4'(b));
  end

  // R19 powers and hold drop at once on deselect
  always_comb begin
    apwr_d = apwr_q;
    dpwr_d = dpwr_q;
    hold_d = hold_q;
    if (!selected) begin
      apwr_d = 1'b0;
      dpwr_d = 1'b0;
      hold_d = 1'b0;
    end else begin
      if (power_on_ev) begin
        apwr_d = 1'b1;
        dpwr_d = 1'b1;
      end
      // Analog side sleeps after the last decision, digital side keeps shifting
      if (analog_off_ev) begin
        apwr_d = 1'b0;
      end
      if (hold_ev) begin
        hold_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      apwr_q <= 1'b0;
      dpwr_q <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      apwr_q <= apwr_d;
      dpwr_q <= dpwr_d;
      hold_q <= hold_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q    <= SARRD_OFF;
      edge_cnt_q <= '0;
      word_q     <= SARRD_RESULT_RST;
      idx_q      <= '0;
      launch_q   <= 1'b0;
      out_q      <= 1'b0;
      oe_q       <= 1'b0;
    end else begin
      state_q    <= state_d;
      edge_cnt_q <= edge_cnt_d;
      word_q     <= word_d;
      idx_q      <= idx_d;
      launch_q   <= launch_d;
      out_q      <= out_d;
      oe_q       <= oe_d;
    end
  end

  assign dec.take    = take_d;
  assign dec.bit_idx = idx_d;
  assign dec.hold    = hold_d && !hold_q;

  // R2 twelve bit decisions
  // R13 code taken as straight binary
  sarrd_sar u_sar (
    .clk         (clk),
    .rst_n       (rst_n),
    .sample_code (code_sync_q),
    .dec         (dec.sar)
  );

  // R14 three wire link pins
  assign serial_data_o    = out_q;
  assign serial_data_oe   = oe_q;
  assign analog_power_up  = apwr_q;
  assign digital_power_up = dpwr_q;
  assign input_hold       = hold_q;
endmodule : sarrd_top

// >>> tb/sarrd_top_assertions.sv
`timescale 1ns/1ns
module sarrd_top_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        select_shutdown_n,
  input wire logic        shift_conversion_clock,
  input wire logic [11:0] sample_code,
  input wire logic        serial_data_o,
  input wire logic        serial_data_oe,
  input wire logic        analog_power_up,
  input wire logic        digital_power_up,
  input wire logic        input_hold
);
  logic       clk_q, sel_q, fall;
  logic [4:0] falls_q, falls_d;
  logic [3:0] fage_q, fage_d, sage_q, sage_d, hi_q, hi_d;
  // Ages saturate so a stalled link never wraps into a false match
  always_comb begin
    fall    = clk_q & ~shift_conversion_clock;
    falls_d = select_shutdown_n ? 5'h00 : falls_q + 5'(fall && falls_q != 5'h1f);
    fage_d  = fall ? 4'h0 : fage_q + 4'(fage_q != 4'hf);
    sage_d  = (select_shutdown_n & ~sel_q) ? 4'h0 : sage_q + 4'(sage_q != 4'hf);
    hi_d    = select_shutdown_n ? hi_q + 4'(hi_q != 4'hf) : 4'h0;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clk_q   <= shift_conversion_clock;
      sel_q   <= select_shutdown_n;
      falls_q <= 5'h00;
      fage_q  <= 4'hf;
      sage_q  <= 4'hf;
      hi_q    <= 4'h0;
    end else begin
      clk_q   <= shift_conversion_clock;
      sel_q   <= select_shutdown_n;
      falls_q <= falls_d;
      fage_q  <= fage_d;
      sage_q  <= sage_d;
      hi_q    <= hi_d;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_zero_off:
    assert property (!serial_data_oe |-> !serial_data_o) else $error("data high while released");
  chk_shut_quiet:
    assert property (hi_q > 4'h5 |-> !(serial_data_oe | analog_power_up | digital_power_up | input_hold))
      else $error("activity while shut down");
  chk_oe_window:
    assert property (serial_data_oe |-> sage_q < 4'h8 || (falls_q >= 5'h02 && falls_q <= 5'h1a))
      else $error("output enabled outside frame window");
  chk_oe_on:
    assert property ((falls_q >= 5'h02 && falls_q <= 5'h19 && fage_q > 4'h8 && hi_q == 4'h0) |-> serial_data_oe)
      else $error("output not enabled in frame");
  chk_oe_release:
    assert property ((falls_q >= 5'h1a && fage_q > 4'h8) |-> !serial_data_oe) else $error("output not released");
  chk_data_on_fall:
    assert property ($changed(serial_data_o) |-> fage_q < 4'h8 || sage_q < 4'h8)
      else $error("data moved away from falling edge");
  chk_hold_kept:
    assert property ($fell(input_hold) |-> sage_q < 4'h8) else $error("hold dropped while selected");
  chk_hold_first:
    assert property ($rose(serial_data_oe) |-> input_hold && digital_power_up) else $error("enabled before hold");
  chk_analog_off:
    assert property ($fell(analog_power_up) |-> (fage_q < 4'h8 && falls_q >= 5'h0f) || sage_q < 4'h8)
      else $error("analog powered down early");
  chk_dig_on:
    assert property ((falls_q >= 5'h01 && fage_q > 4'h8 && hi_q == 4'h0) |-> digital_power_up)
      else $error("digital side off while selected");
  cover property ($fell(serial_data_oe) && falls_q >= 5'h1a);
  cover property ($fell(serial_data_oe) && falls_q < 5'h02);
  cover property ($fell(analog_power_up));
endmodule : sarrd_top_chk
bind sarrd_top sarrd_top_chk chk (.clk(clk), .rst_n(rst_n), .select_shutdown_n(select_shutdown_n),
  .shift_conversion_clock(shift_conversion_clock), .sample_code(sample_code), .serial_data_o(serial_data_o),
  .serial_data_oe(serial_data_oe), .analog_power_up(analog_power_up), .digital_power_up(digital_power_up),
  .input_hold(input_hold));

// >>> tb/sarrd_host.sv
`timescale 1ns/1ns
module sarrd_host (
  input  wire logic        clk,
  input  wire logic        serial_data_o,
  input  wire logic        serial_data_oe,
  input  wire logic        analog_power_up,
  input  wire logic        input_hold,
  output logic             select_shutdown_n,
  output logic             shift_conversion_clock,
  output logic [11:0]      sample_code
);
  localparam int HALF = 10;
  logic [3:0] cap [32];
  initial begin
    select_shutdown_n = 1'b1;
    shift_conversion_clock = 1'b0;
    sample_code = 12'h000;
  end
  task frame(input logic [11:0] code, input int n, input int gap);
    sample_code <= code;
    select_shutdown_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      repeat (HALF) @(posedge clk);
      cap[i] = {input_hold, analog_power_up, serial_data_oe, serial_data_o};
      shift_conversion_clock <= 1'b1;
      repeat (HALF) @(posedge clk);
      shift_conversion_clock <= 1'b0;
      // Input moves after capture, so a resample would show
      if (i == 2) sample_code <= ~code;
    end
    repeat (HALF) @(posedge clk);
    cap[n] = {input_hold, analog_power_up, serial_data_oe, serial_data_o};
    select_shutdown_n <= 1'b1;
    repeat (gap) @(posedge clk);
  endtask : frame
  task idle(input int n);
    // Ends on a full low half, so no fall coincides with the next select edge
    repeat (n) begin
      shift_conversion_clock <= 1'b1;
      repeat (HALF) @(posedge clk);
      shift_conversion_clock <= 1'b0;
      repeat (HALF) @(posedge clk);
    end
  endtask : idle
endmodule : sarrd_host

// >>> tb/sarrd_top_bench.sv
`timescale 1ns/1ns
module sarrd_top_bench;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        sel, dclk, sdo, soe, apu, dpu, hold;
  logic [11:0] code;
  int          miscompares = 0;
  int          samples_checked = 0;
  always #10 clk = ~clk;
  sarrd_top dut (.clk(clk), .rst_n(rst_n), .select_shutdown_n(sel), .shift_conversion_clock(dclk),
    .sample_code(code), .serial_data_o(sdo), .serial_data_oe(soe), .analog_power_up(apu),
    .digital_power_up(dpu), .input_hold(hold));
  sarrd_host host (.clk(clk), .serial_data_o(sdo), .serial_data_oe(soe), .analog_power_up(apu),
    .input_hold(hold), .select_shutdown_n(sel), .shift_conversion_clock(dclk), .sample_code(code));
  task check(input logic [3:0] got, input logic [3:0] exp, input int k);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t step %0d got %h want %h", $time, k, got, exp);
    end
  endtask : check
  function automatic logic [3:0] expect_at(input logic [11:0] c, input int k);
    logic d;
    d = (k >= 3 && k <= 14) ? c[14-k] : (k >= 15 && k <= 25) ? c[k-14] : 1'b0;
    return {k >= 2, k <= 14, k >= 2 && k <= 25, d};
  endfunction : expect_at
  task t_idle;
    host.idle(30);
    check({hold, apu, soe, dpu}, 4'h0, 0);
    $display("test idle done");
  endtask : t_idle
  task t_abort;
    host.frame(12'h3c9, 8, 6);
    for (int k = 0; k <= 8; k++) check(host.cap[k], expect_at(12'h3c9, k), k);
    check({hold, apu, soe, dpu}, 4'h0, 9);
    $display("test abort done");
  endtask : t_abort
  task t_frames;
    logic [11:0] codes [5];
    codes = '{12'ha5c, 12'hfff, 12'h800, 12'h7ff, 12'h000};
    foreach (codes[j]) begin
      host.frame(codes[j], 30, 12);
      for (int k = 0; k <= 30; k++) check(host.cap[k], expect_at(codes[j], k), k);
      check({hold, apu, soe, dpu}, 4'h0, 31);
    end
    $display("test frames done");
  endtask : t_frames
  task test_done;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_idle();
    t_abort();
    t_frames();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    test_done();
  end
endmodule : sarrd_top_bench
